/* logic/bbp_pkg.sv */
// Package of constants and carrier types for the boolean bit processor.
`default_nettype none
package bbp_pkg;
  localparam int unsigned WORD_W       = 24;
  localparam int unsigned ADDR_W       = 20;
  localparam int unsigned COND_W       = 4;
  localparam int unsigned COND_ZERO_POS = 2;
  localparam int unsigned OP1_LSB      = 12;
  localparam int unsigned OP2_LSB      = 13;
  localparam int unsigned BITSEL_LSB   = 8;
  localparam int unsigned BITSEL_W     = 5;
  localparam int unsigned DISP_W       = 8;
  localparam int unsigned COMPAT_W     = 18;
  localparam logic [4:0]  BITSEL_MAX   = 5'h17;
  localparam logic [11:0] OP_CLR_FLAG  = 12'hFE2;
  localparam logic [11:0] OP_SET_FLAG  = 12'hFE3;
  localparam logic [11:0] OP_LD_BASE   = 12'hFE4;
  localparam logic [11:0] OP_ST_BASE   = 12'hFE5;
  localparam logic [11:0] OP_QRY_FLAG  = 12'hFE6;
  localparam logic [11:0] OP_INV_FLAG  = 12'hFE7;
  localparam logic [10:0] OP_AND_MEM   = 11'h7F4;
  localparam logic [10:0] OP_ANDN_MEM  = 11'h7F5;
  localparam logic [10:0] OP_OR_MEM    = 11'h7F6;
  localparam logic [10:0] OP_ORN_MEM   = 11'h7F7;
  localparam logic [10:0] OP_XOR_MEM   = 11'h7F8;
  localparam logic [10:0] OP_XORN_MEM  = 11'h7F9;
  localparam logic [10:0] OP_LD_FLAG   = 11'h7FA;
  localparam logic [10:0] OP_SET_MEM   = 11'h7FB;
  localparam logic [10:0] OP_CLR_MEM   = 11'h7FC;
  localparam logic [10:0] OP_QRY_MEM   = 11'h7FD;
  localparam logic [WORD_W-1:0] KREG_RST = 24'h000000;
  localparam logic [ADDR_W-1:0] BASE_RST = 20'h00000;

  typedef enum logic [4:0] {
    BBP_OP_NONE, BBP_OP_CLR_FLAG, BBP_OP_SET_FLAG, BBP_OP_LD_BASE, BBP_OP_ST_BASE,
    BBP_OP_QRY_FLAG, BBP_OP_INV_FLAG, BBP_OP_AND, BBP_OP_ANDN, BBP_OP_OR, BBP_OP_ORN,
    BBP_OP_XOR, BBP_OP_XORN, BBP_OP_LD_FLAG, BBP_OP_SET_MEM, BBP_OP_CLR_MEM,
    BBP_OP_QRY_MEM
  } bbp_op_t;

  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] word;
  } bbp_instr_t;

  typedef struct packed {
    bbp_op_t            op;
    logic [BITSEL_W-1:0] bitsel;
    logic [DISP_W-1:0]  disp;
  } bbp_dec_t;

  typedef struct packed {
    logic              req;
    logic              we;
    logic              lock;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } bbp_mem_req_t;
endpackage : bbp_pkg
`default_nettype wire

/* logic/bbp_decode.sv */
// Instruction decoder for the boolean bit processor.
`default_nettype none
module bbp_decode
  import bbp_pkg::*;
(
  input  wire logic [bbp_pkg::WORD_W-1:0] word_i,
  output bbp_pkg::bbp_dec_t               dec_o
);
  import bbp_pkg::*;

  always_comb begin
    dec_o.disp   = word_i[DISP_W-1:0]; // RQ2
    dec_o.bitsel = word_i[BITSEL_LSB +: BITSEL_W]; // RQ3
    dec_o.op     = BBP_OP_NONE;
    unique case (word_i[WORD_W-1:OP1_LSB]) // RQ1
      OP_CLR_FLAG: dec_o.op = BBP_OP_CLR_FLAG;
      OP_SET_FLAG: dec_o.op = BBP_OP_SET_FLAG;
      OP_LD_BASE:  dec_o.op = BBP_OP_LD_BASE;
      OP_ST_BASE:  dec_o.op = BBP_OP_ST_BASE;
      OP_QRY_FLAG: dec_o.op = BBP_OP_QRY_FLAG;
      OP_INV_FLAG: dec_o.op = BBP_OP_INV_FLAG;
      default: begin
        unique case (word_i[WORD_W-1:OP2_LSB]) // RQ3
          OP_AND_MEM:  dec_o.op = BBP_OP_AND;
          OP_ANDN_MEM: dec_o.op = BBP_OP_ANDN;
          OP_OR_MEM:   dec_o.op = BBP_OP_OR;
          OP_ORN_MEM:  dec_o.op = BBP_OP_ORN;
          OP_XOR_MEM:  dec_o.op = BBP_OP_XOR;
          OP_XORN_MEM: dec_o.op = BBP_OP_XORN;
          OP_LD_FLAG:  dec_o.op = BBP_OP_LD_FLAG;
          OP_SET_MEM:  dec_o.op = BBP_OP_SET_MEM;
          OP_CLR_MEM:  dec_o.op = BBP_OP_CLR_MEM;
          OP_QRY_MEM:  dec_o.op = BBP_OP_QRY_MEM;
          default:     dec_o.op = BBP_OP_NONE;
        endcase
      end
    endcase
  end
endmodule : bbp_decode
`default_nettype wire

/* logic/bbp_core.sv */
// Boolean bit processor execution core.
// Summary of operation
// (RQ1) First form: opcode in bits 23-12, bits 11-0 ignored.
// (RQ2) Second form: effective address is base pointer plus 8-bit displacement.
// (RQ3) Second form: bits 12-8 select bit, bits 23-13 hold the opcode.
// (RQ4) Software keeps bit selector at 23 or below; larger values read zero.
// (RQ5) Reporting ops clear condition, then bit 2 set when reported value is zero.
// (RQ6) Clear flag: flag becomes zero, old flag reported.
// (RQ7) Set flag: flag becomes one, old flag reported.
// (RQ8) Load base from index: 18 or 20 low bits by mode; condition kept.
// (RQ9) Store base to index: low 18 or 20 bits, upper zeroed; condition kept.
// (RQ10) Query flag: flag kept, its value reported.
// (RQ11) Invert flag: flag complemented, new value reported.
// (RQ12) AND memory bit into flag, report result.
// (RQ13) AND inverted memory bit into flag, report result.
// (RQ14) OR memory bit into flag, report result.
// (RQ15) OR inverted memory bit into flag, report result.
// (RQ16) XOR memory bit into flag, report result.
// (RQ17) XOR inverted memory bit into flag, report result.
// (RQ18) Load flag from memory bit, report new flag.
// (RQ19) Set memory bit to one; condition untouched.
// (RQ20) Query memory bit without changing memory, report it.
// (RQ21) Clear memory bit, report its old value.
// (RQ22) Clear memory bit holds DMA block and memory lock throughout.
// (RQ23) Memory writes read the word, change one bit, write the word back.
`default_nettype none
module bbp_core
  import bbp_pkg::*;
(
  input  wire logic                       ref_clk_i,
  input  wire logic                       sys_rst_i,
  input  wire bbp_pkg::bbp_instr_t        instr_i,
  input  wire logic                       ext_mode_i,
  input  wire logic                       k_wr_i,
  input  wire logic [bbp_pkg::WORD_W-1:0] k_wdata_i,
  input  wire logic                       mem_ack_i,
  input  wire logic [bbp_pkg::WORD_W-1:0] mem_rdata_i,
  output bbp_pkg::bbp_mem_req_t           mem_o,
  output logic                            dma_block_o,
  output logic                            busy_o,
  output logic                            done_o,
  output logic                            flag_o,
  output logic [bbp_pkg::COND_W-1:0]      cond_o,
  output logic [bbp_pkg::WORD_W-1:0]      k_o,
  output logic [bbp_pkg::ADDR_W-1:0]      base_o
);
  import bbp_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_READ  = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_DONE  = 4'b1000
  } bbp_state_t;

  function automatic logic pick_bit(input logic [WORD_W-1:0] w, input logic [BITSEL_W-1:0] s);
    pick_bit = (s > BITSEL_MAX) ? 1'b0 : w[s]; // RQ4
  endfunction : pick_bit

  function automatic logic [COND_W-1:0] zero_cond(input logic v);
    zero_cond = '0; // RQ5
    zero_cond[COND_ZERO_POS] = ~v; // RQ5
  endfunction : zero_cond

  bbp_dec_t dec;
  bbp_state_t state_reg, state_next;
  bbp_op_t op_reg, op_next;
  logic [BITSEL_W-1:0] sel_reg, sel_next;
  logic [WORD_W-1:0] word_reg, word_next;
  logic flag_reg, flag_next;
  logic [COND_W-1:0] cond_reg, cond_next;
  logic [WORD_W-1:0] k_reg, k_next;
  logic [ADDR_W-1:0] base_reg, base_next;
  bbp_mem_req_t mem_reg, mem_next;
  logic dma_reg, dma_next;
  logic done_reg, done_next;
  logic busy_reg, busy_next;
  logic mbit;
  logic [WORD_W-1:0] bit_mask;
  logic [ADDR_W-1:0] ea;

  bbp_decode u_decode (
    .word_i (instr_i.word),
    .dec_o  (dec)
  );

  assign mbit     = pick_bit(word_reg, sel_reg);
  assign bit_mask = (sel_reg > BITSEL_MAX) ? '0 : (WORD_W'(1) << sel_reg);
  assign ea       = base_reg + ADDR_W'(dec.disp); // RQ2

  always_comb begin
    state_next = state_reg;
    op_next    = op_reg;
    sel_next   = sel_reg;
    word_next  = word_reg;
    flag_next  = flag_reg;
    cond_next  = cond_reg;
    k_next     = k_wr_i ? k_wdata_i : k_reg;
    base_next  = base_reg;
    mem_next   = mem_reg;
    dma_next   = dma_reg;
    done_next  = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (instr_i.valid) begin
          op_next  = dec.op;
          sel_next = dec.bitsel;
          unique case (dec.op)
            BBP_OP_CLR_FLAG: begin
              flag_next = 1'b0; // RQ6
              cond_next = zero_cond(flag_reg); // RQ6
              done_next = 1'b1;
            end
            BBP_OP_SET_FLAG: begin
              flag_next = 1'b1; // RQ7
              cond_next = zero_cond(flag_reg); // RQ7
              done_next = 1'b1;
            end
            BBP_OP_LD_BASE: begin
              base_next = ext_mode_i ? k_reg[ADDR_W-1:0]
                                     : ADDR_W'(k_reg[COMPAT_W-1:0]); // RQ8
              done_next = 1'b1;
            end
            BBP_OP_ST_BASE: begin
              k_next = ext_mode_i ? WORD_W'(base_reg)
                                  : WORD_W'(base_reg[COMPAT_W-1:0]); // RQ9
              done_next = 1'b1;
            end
            BBP_OP_QRY_FLAG: begin
              cond_next = zero_cond(flag_reg); // RQ10
              done_next = 1'b1;
            end
            BBP_OP_INV_FLAG: begin
              flag_next = ~flag_reg; // RQ11
              cond_next = zero_cond(~flag_reg); // RQ11
              done_next = 1'b1;
            end
            BBP_OP_NONE: begin
              done_next = 1'b1;
            end
            default: begin
              mem_next.req   = 1'b1;
              mem_next.we    = 1'b0;
              mem_next.addr  = ea;
              mem_next.lock  = (dec.op == BBP_OP_CLR_MEM); // RQ22
              dma_next       = (dec.op == BBP_OP_CLR_MEM); // RQ22
              state_next     = ST_READ;
            end
          endcase
        end
      end
      ST_READ: begin
        if (mem_ack_i) begin
          word_next   = mem_rdata_i;
          mem_next.req = 1'b0;
          state_next  = ST_WRITE;
        end
      end
      ST_WRITE: begin
        unique case (op_reg)
          BBP_OP_AND:     flag_next = flag_reg & mbit; // RQ12
          BBP_OP_ANDN:    flag_next = flag_reg & ~mbit; // RQ13
          BBP_OP_OR:      flag_next = flag_reg | mbit; // RQ14
          BBP_OP_ORN:     flag_next = flag_reg | ~mbit; // RQ15
          BBP_OP_XOR:     flag_next = flag_reg ^ mbit; // RQ16
          BBP_OP_XORN:    flag_next = flag_reg ^ ~mbit; // RQ17
          BBP_OP_LD_FLAG: flag_next = mbit; // RQ18
          default:        flag_next = flag_reg;
        endcase
        unique case (op_reg)
          BBP_OP_SET_MEM: begin
            mem_next.req   = 1'b1;
            mem_next.we    = 1'b1;
            mem_next.wdata = word_reg | bit_mask; // RQ19 RQ23
            state_next     = ST_DONE;
          end
          BBP_OP_CLR_MEM: begin
            mem_next.req   = 1'b1;
            mem_next.we    = 1'b1;
            mem_next.wdata = word_reg & ~bit_mask; // RQ21 RQ23
            cond_next      = zero_cond(mbit); // RQ21
            state_next     = ST_DONE;
          end
          BBP_OP_QRY_MEM: begin
            cond_next  = zero_cond(mbit); // RQ20
            done_next  = 1'b1;
            state_next = ST_IDLE;
          end
          default: begin
            cond_next  = zero_cond(flag_next); // RQ5
            done_next  = 1'b1;
            state_next = ST_IDLE;
          end
        endcase
      end
      ST_DONE: begin
        if (mem_ack_i) begin
          mem_next.req  = 1'b0;
          mem_next.we   = 1'b0;
          mem_next.lock = 1'b0; // RQ22
          dma_next      = 1'b0; // RQ22
          done_next     = 1'b1;
          state_next    = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    busy_next = (state_next != ST_IDLE);
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_IDLE;
      op_reg    <= BBP_OP_NONE;
      sel_reg   <= '0;
      word_reg  <= '0;
      flag_reg  <= 1'b0;
      cond_reg  <= '0;
      k_reg     <= KREG_RST;
      base_reg  <= BASE_RST;
      mem_reg   <= '0;
      dma_reg   <= 1'b0;
      done_reg  <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg    <= op_next;
      sel_reg   <= sel_next;
      word_reg  <= word_next;
      flag_reg  <= flag_next;
      cond_reg  <= cond_next;
      k_reg     <= k_next;
      base_reg  <= base_next;
      mem_reg   <= mem_next;
      dma_reg   <= dma_next;
      done_reg  <= done_next;
      busy_reg  <= busy_next;
    end
  end

  assign mem_o       = mem_reg;
  assign dma_block_o = dma_reg;
  assign busy_o      = busy_reg;
  assign done_o      = done_reg;
  assign flag_o      = flag_reg;
  assign cond_o      = cond_reg;
  assign k_o         = k_reg;
  assign base_o      = base_reg;

  sequence s_clr_start;
    state_reg == ST_IDLE && instr_i.valid && dec.op == BBP_OP_CLR_MEM;
  endsequence

  chk_clr_flag_old: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ6
    (state_reg == ST_IDLE && instr_i.valid && dec.op == BBP_OP_CLR_FLAG) |=>
      (!flag_reg && cond_reg == zero_cond($past(flag_reg))))
    else $error("clear flag result wrong");
  chk_set_flag_old: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ7
    (state_reg == ST_IDLE && instr_i.valid && dec.op == BBP_OP_SET_FLAG) |=>
      (flag_reg && cond_reg[COND_ZERO_POS] == !$past(flag_reg)))
    else $error("set flag result wrong");
  chk_inv_flag_new: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ11
    (state_reg == ST_IDLE && instr_i.valid && dec.op == BBP_OP_INV_FLAG) |=>
      (flag_reg != $past(flag_reg) && cond_reg[COND_ZERO_POS] == !flag_reg))
    else $error("invert flag result wrong");
  chk_base_keep_cond: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ8
    (state_reg == ST_IDLE && instr_i.valid && dec.op == BBP_OP_LD_BASE && !ext_mode_i) |=>
      (base_reg[ADDR_W-1:COMPAT_W] == '0 && $stable(cond_reg)))
    else $error("base load wrong");
  chk_k_upper_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ9
    (state_reg == ST_IDLE && instr_i.valid && dec.op == BBP_OP_ST_BASE && !k_wr_i) |=>
      (k_reg[WORD_W-1:ADDR_W] == '0 && $stable(cond_reg)))
    else $error("index store upper bits not zero");
  chk_ea_sum: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ2
    (state_reg == ST_IDLE && instr_i.valid && dec.op inside {BBP_OP_AND, BBP_OP_QRY_MEM}) |=>
      (mem_reg.req && !mem_reg.we &&
       mem_reg.addr == $past(base_reg) + ADDR_W'($past(instr_i.word[DISP_W-1:0]))))
    else $error("effective address wrong");
  chk_clr_lock_held: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ22
    s_clr_start |=> (dma_block_o && mem_reg.lock) throughout (state_reg != ST_IDLE)[*2])
    else $error("lock dropped during clear");
  chk_wb_one_bit: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ23
    (mem_reg.req && mem_reg.we) |->
      ($countones(mem_reg.wdata ^ word_reg) <= 1))
    else $error("write back changed other bits");
  chk_set_no_cond: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ19
    (state_reg == ST_WRITE && op_reg == BBP_OP_SET_MEM) |=> $stable(cond_reg))
    else $error("set memory bit altered condition");
  chk_flag_report: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ5
    (state_reg == ST_WRITE && op_reg inside {BBP_OP_AND, BBP_OP_OR, BBP_OP_XOR, BBP_OP_LD_FLAG})
      |=> (done_reg && cond_reg == zero_cond(flag_reg)))
    else $error("flag report wrong");
  chk_qry_flag_keep: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ10
    (state_reg == ST_IDLE && instr_i.valid && dec.op == BBP_OP_QRY_FLAG) |=>
      ($stable(flag_reg) && cond_reg == zero_cond(flag_reg)))
    else $error("query flag result wrong");
  chk_qry_mem_keep: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ20
    (state_reg == ST_WRITE && op_reg == BBP_OP_QRY_MEM) |=>
      (!mem_reg.we && done_reg && cond_reg == zero_cond($past(mbit))))
    else $error("query memory bit result wrong");
  chk_unknown_noop: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ1
    (state_reg == ST_IDLE && instr_i.valid && dec.op == BBP_OP_NONE) |=>
      (done_reg && $stable(flag_reg) && $stable(cond_reg) && $stable(base_reg)))
    else $error("unknown opcode had an effect");
endmodule : bbp_core
`default_nettype wire

/* test/bbp_mem_model.sv */
// Main memory model that answers the bit processor after a random delay.
`default_nettype none
module bbp_mem_model
  import bbp_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire bbp_pkg::bbp_mem_req_t mem_i,
  input  wire logic                  dma_block_i,
  output logic                       mem_ack_o,
  output logic [bbp_pkg::WORD_W-1:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [WORD_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] last_addr;
  int                wait_cnt;
  int                wr_cnt;
  int                held_cnt;
  initial begin
    mem_ack_o = 1'b0;
    mem_rdata_o = 24'h5A5A5A;
    last_addr = 20'h00000;
    wait_cnt = 0;
    wr_cnt = 0;
    held_cnt = 0;
  end
  always @(negedge ref_clk_i) begin
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (mem_i.req && !mem_ack_o) begin
      if (wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
      end else begin
        mem_ack_o <= 1'b1;
        last_addr <= mem_i.addr;
        wait_cnt <= $urandom_range(3, 0);
        held_cnt <= held_cnt + int'(mem_i.lock && dma_block_i);
        if (mem_i.we) begin
          mem[mem_i.addr] = mem_i.wdata;
          wr_cnt <= wr_cnt + 1;
        end else begin
          mem_rdata_o <= mem.exists(mem_i.addr) ? mem[mem_i.addr] : 24'h000000;
        end
      end
    end
  end
endmodule : bbp_mem_model
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the boolean bit processor core.
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("mismatch at %0t got %h exp %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bbp_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  bbp_instr_t instr = '0;
  logic ext_mode = 1'b0;
  logic k_wr = 1'b0;
  logic [WORD_W-1:0] k_wdata = 24'h000000;
  logic mem_ack;
  logic [WORD_W-1:0] mem_rdata;
  bbp_mem_req_t mem_req;
  logic dma_block, busy, done, flag;
  logic [COND_W-1:0] cond;
  logic [WORD_W-1:0] k_val;
  logic [ADDR_W-1:0] base_val;
  int failures = 0;
  int total_checks = 0;
  logic exp_flag = 1'b0;
  logic [COND_W-1:0] exp_cond = 4'h0;
  logic [WORD_W-1:0] exp_k = 24'h000000;
  logic [ADDR_W-1:0] exp_base = 20'h00000;
  localparam logic [11:0] FIRST_OPS [6] = '{OP_CLR_FLAG, OP_SET_FLAG, OP_LD_BASE,
    OP_ST_BASE, OP_QRY_FLAG, OP_INV_FLAG};
  localparam logic [10:0] SEC_OPS [10] = '{OP_AND_MEM, OP_ANDN_MEM, OP_OR_MEM,
    OP_ORN_MEM, OP_XOR_MEM, OP_XORN_MEM, OP_LD_FLAG, OP_SET_MEM, OP_CLR_MEM, OP_QRY_MEM};

  always #4 ref_clk_i = ~ref_clk_i;

  bbp_core u_bbp_core (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .instr_i(instr),
    .ext_mode_i(ext_mode), .k_wr_i(k_wr), .k_wdata_i(k_wdata), .mem_ack_i(mem_ack),
    .mem_rdata_i(mem_rdata), .mem_o(mem_req), .dma_block_o(dma_block), .busy_o(busy),
    .done_o(done), .flag_o(flag), .cond_o(cond), .k_o(k_val), .base_o(base_val));
  bbp_mem_model u_bbp_mem_model (.ref_clk_i(ref_clk_i), .mem_i(mem_req),
    .dma_block_i(dma_block), .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata));

  task automatic run_op(input int unsigned i, input logic [4:0] sel);
    logic [WORD_W-1:0] w, old_w, new_w;
    logic [ADDR_W-1:0] ea;
    logic [7:0] disp;
    logic mb, rep, rep_en;
    int n;
    disp = 8'($urandom);
    old_w = 24'($urandom);
    ea = exp_base + {12'h000, disp};
    mb = old_w[sel];
    new_w = old_w;
    rep_en = 1'b1;
    rep = 1'b0;
    @(negedge ref_clk_i);
    k_wr = ($urandom_range(3, 0) == 0);
    k_wdata = 24'($urandom);
    ext_mode = 1'($urandom);
    if (k_wr) exp_k = k_wdata;
    if (i < 6) w = {FIRST_OPS[i], 12'($urandom)};
    else if (i < 16) w = {SEC_OPS[i-6], sel, disp};
    else w = {12'h000, 12'($urandom)};
    if (i >= 6) u_bbp_mem_model.mem[ea] = old_w;
    u_bbp_mem_model.wr_cnt = 0;
    u_bbp_mem_model.held_cnt = 0;
    case (i)
      0: begin rep = exp_flag; exp_flag = 1'b0; end
      1: begin rep = exp_flag; exp_flag = 1'b1; end
      2: begin rep_en = 1'b0; exp_base = ext_mode ? exp_k[19:0] : {2'b00, exp_k[17:0]}; end
      3: begin rep_en = 1'b0; exp_k = ext_mode ? {4'h0, exp_base} : {6'h00, exp_base[17:0]}; end
      4: rep = exp_flag;
      5: begin exp_flag = ~exp_flag; rep = exp_flag; end
      6: exp_flag = exp_flag & mb;
      7: exp_flag = exp_flag & ~mb;
      8: exp_flag = exp_flag | mb;
      9: exp_flag = exp_flag | ~mb;
      10: exp_flag = exp_flag ^ mb;
      11: exp_flag = exp_flag ^ ~mb;
      12: exp_flag = mb;
      13: begin rep_en = 1'b0; new_w[sel] = 1'b1; end
      14: begin rep = mb; new_w[sel] = 1'b0; end
      15: rep = mb;
      default: rep_en = 1'b0;
    endcase
    if (i >= 6 && i <= 12) rep = exp_flag;
    if (rep_en) exp_cond = rep ? 4'h0 : 4'h4;
    @(negedge ref_clk_i);
    k_wr = 1'b0;
    instr.valid = 1'b1;
    instr.word = w;
    @(negedge ref_clk_i);
    instr.valid = 1'b0;
    if (i >= 6 && i < 16) `CHK(busy, 1'b1)
    for (n = 0; n < 40 && done !== 1'b1; n++) @(negedge ref_clk_i);
    `CHK(done, 1'b1)
    `CHK(busy, 1'b0)
    `CHK(flag, exp_flag)
    `CHK(cond, exp_cond)
    `CHK(k_val, exp_k)
    `CHK(base_val, exp_base)
    if (i >= 6 && i < 16) begin
      `CHK(u_bbp_mem_model.last_addr, ea)
      `CHK(u_bbp_mem_model.mem[ea], new_w)
      `CHK(u_bbp_mem_model.wr_cnt, int'(i == 13 || i == 14))
    end
    if (i == 14) `CHK(u_bbp_mem_model.held_cnt, 2)
  endtask : run_op

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  initial begin
    #(8 * 30000);
    failures++;
    wrap_up();
  end

  initial begin
    void'($urandom(34197));
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    `CHK(flag, 1'b0)
    `CHK(cond, 4'h0)
    `CHK(k_val, KREG_RST)
    `CHK(base_val, BASE_RST)
    $display("test reset done");
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 17; i++) run_op(i, s ? 5'h00 : BITSEL_MAX);
    end
    $display("test every op done");
    for (int j = 0; j < 400; j++) run_op($urandom_range(16, 0), 5'($urandom_range(23, 0)));
    $display("test random ops done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
